// ==== rtl/cps_sequencer.sv ====
`timescale 1ns/100ps
`include "cps_map.svh"
// Functional notes
// - low level on restart input starts a new configuration sequence
// - init and done status pins are only pulled low or released
// - init status pin pulled low as soon as a sequence starts
// - init pin released when init ends; download only after release
// - download waits while init pin reads low
// - done pin held low throughout configuration
// - done pin released once configuration completes successfully
// - user mode not entered while done pin reads low
// - unused user pads tri-stated with pull-down during configuration
// - unused pads after configuration stay tri-stated with pull-down
// - slave SPI or I2C/I3C interface chosen at slave activation
// - shared pads unused by the mode are tri-stated during configuration
// - after completion shared pads go to user design
// - slave SPI uses four shared pads: out, in, select, clock
// - master SPI drives clock, select, data out and samples data in
// - quad SPI uses four bidirectional data pads reusing SPI data pads
// - daisy chain drives chip-select output to next device
// - I2C/I3C uses SDA and SCL pads; user mode may reuse them
// - user mode with JTAG select 1 maps slave SPI pads to JTAG
// - JTAG select 0 gives general use, 1 gives JTAG
module cps_sequencer (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic config_restart_n_i,
   input wire logic init_state_n_i,
   output logic init_state_n_o,
   output logic init_state_n_oe_o,
   input wire logic done_n_i,
   output logic done_n_o,
   output logic done_n_oe_o,
   input wire logic slave_spi_active_i,
   input wire logic slave_i2c_active_i,
   input wire logic master_mode_i,
   input wire logic quad_mode_i,
   input wire logic chain_mode_i,
   input wire logic load_ok_i,
   input wire logic jtag_sel_i,
   output logic load_busy_o,
   output logic user_mode_o,
   output logic [2:0] mode_o,
   input wire logic [`CPS_NUM_SHARED-1:0] shared_pad_i,
   output logic [`CPS_NUM_SHARED-1:0] shared_pad_o,
   output logic [`CPS_NUM_SHARED-1:0] shared_pad_oe_o,
   output logic [`CPS_NUM_SHARED-1:0] shared_pad_pd_o,
   input wire logic cfg_sout_i,
   input wire logic cfg_sck_i,
   input wire logic cfg_cs_n_i,
   input wire logic [3:0] cfg_qout_i,
   input wire logic [3:0] cfg_qoe_i,
   input wire logic cfg_sda_oe_i,
   input wire logic cfg_chain_cs_n_i,
   output logic [3:0] cfg_din_o,
   output logic cfg_sck_o,
   output logic cfg_cs_n_o,
   output logic cfg_scl_o,
   input wire logic [`CPS_NUM_SHARED-1:0] user_pad_out_i,
   input wire logic [`CPS_NUM_SHARED-1:0] user_pad_oe_i,
   input wire logic [`CPS_NUM_SHARED-1:0] user_pad_used_i,
   output logic [`CPS_NUM_SHARED-1:0] user_pad_in_o,
   input wire logic jtag_tdo_i,
   output logic jtag_tdi_o,
   output logic jtag_tms_o,
   output logic jtag_tck_o,
   input wire logic [`CPS_NUM_USER-1:0] top_user_pad_i,
   input wire logic [`CPS_NUM_USER-1:0] top_user_pad_out_i,
   input wire logic [`CPS_NUM_USER-1:0] top_user_pad_oe_i,
   input wire logic [`CPS_NUM_USER-1:0] top_user_pad_used_i,
   output logic [`CPS_NUM_USER-1:0] top_user_pad_o,
   output logic [`CPS_NUM_USER-1:0] top_user_pad_oe_o,
   output logic [`CPS_NUM_USER-1:0] top_user_pad_pd_o,
   output logic [`CPS_NUM_USER-1:0] top_user_pad_in_o
);
   cps_pkg::cps_state_type state_q;
   logic [`CPS_INIT_W-1:0] init_cnt_q;
   logic [2:0] mode_q;
   logic restart_s;
   logic init_s;
   logic done_s;
   logic [`CPS_NUM_SHARED-1:0] cfg_use;
   logic [`CPS_NUM_SHARED-1:0] cfg_out;
   logic [`CPS_NUM_SHARED-1:0] cfg_oe;
   logic cfg_phase;
   logic user_phase;
   cps_sync_if sif ();

   // pin levels into the clock domain
   assign sif.raw = {config_restart_n_i, init_state_n_i, done_n_i};
   assign restart_s = sif.synced[2];
   assign init_s = sif.synced[1];
   assign done_s = sif.synced[0];

   cps_sync2 u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sif(sif)
   );

   // configuration sequence
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= cps_pkg::CPS_ST_IDLE;
      end else if (!restart_s) begin
         state_q <= cps_pkg::CPS_ST_INIT;
      end else begin
         case (state_q)
            cps_pkg::CPS_ST_IDLE: begin
               state_q <= cps_pkg::CPS_ST_INIT;
            end
            cps_pkg::CPS_ST_INIT: begin
               if (init_cnt_q == `CPS_INIT_CYCLES) begin
                  state_q <= cps_pkg::CPS_ST_WAIT_INIT;
               end
            end
            cps_pkg::CPS_ST_WAIT_INIT: begin
               if (init_s) begin
                  state_q <= cps_pkg::CPS_ST_LOAD;
               end
            end
            cps_pkg::CPS_ST_LOAD: begin
               if (load_ok_i) begin
                  state_q <= cps_pkg::CPS_ST_WAIT_DONE;
               end
            end
            cps_pkg::CPS_ST_WAIT_DONE: begin
               if (done_s) begin
                  state_q <= cps_pkg::CPS_ST_USER;
               end
            end
            cps_pkg::CPS_ST_USER: begin
               state_q <= cps_pkg::CPS_ST_USER;
            end
            default: begin
               state_q <= cps_pkg::CPS_ST_IDLE;
            end
         endcase
      end
   end

   // initialization timer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || state_q != cps_pkg::CPS_ST_INIT) begin
         init_cnt_q <= '0;
      end else if (init_cnt_q != `CPS_INIT_CYCLES) begin
         init_cnt_q <= init_cnt_q + `CPS_INIT_W'(1);
      end
   end

   // mode capture at slave activation
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode_q <= `CPS_MODE_SSPI;
      end else if (state_q == cps_pkg::CPS_ST_WAIT_INIT && init_s) begin
         if (slave_i2c_active_i && !slave_spi_active_i) begin
            mode_q <= `CPS_MODE_I2C;
         end else if (slave_spi_active_i) begin
            mode_q <= `CPS_MODE_SSPI;
         end else if (chain_mode_i) begin
            mode_q <= `CPS_MODE_CHAIN;
         end else if (quad_mode_i) begin
            mode_q <= `CPS_MODE_MQSPI;
         end else if (master_mode_i) begin
            mode_q <= `CPS_MODE_MSPI;
         end else begin
            mode_q <= `CPS_MODE_SSPI;
         end
      end
   end

   assign cfg_phase = (state_q != cps_pkg::CPS_ST_USER);
   assign user_phase = (state_q == cps_pkg::CPS_ST_USER);
   assign load_busy_o = (state_q == cps_pkg::CPS_ST_LOAD);
   assign user_mode_o = user_phase;
   assign mode_o = mode_q;

   // open-drain status pins: output always low, only enable moves
   assign init_state_n_o = 1'b0;
   assign done_n_o = 1'b0;
   assign init_state_n_oe_o = (state_q == cps_pkg::CPS_ST_INIT) || (state_q == cps_pkg::CPS_ST_IDLE);
   assign done_n_oe_o = (state_q != cps_pkg::CPS_ST_WAIT_DONE) && cfg_phase;

   // pad roles for the captured configuration mode
   always_comb begin
      cfg_use = '0;
      cfg_out = '0;
      cfg_oe = '0;
      if (state_q == cps_pkg::CPS_ST_LOAD) begin
         case (mode_q)
            `CPS_MODE_SSPI: begin
               cfg_use[`CPS_PAD_SOUT] = 1'b1;
               cfg_use[`CPS_PAD_SIN] = 1'b1;
               cfg_use[`CPS_PAD_SCS] = 1'b1;
               cfg_use[`CPS_PAD_SCK] = 1'b1;
               cfg_out[`CPS_PAD_SOUT] = cfg_sout_i;
               cfg_oe[`CPS_PAD_SOUT] = !shared_pad_i[`CPS_PAD_SCS];
            end
            `CPS_MODE_I2C: begin
               cfg_use[`CPS_PAD_SDA] = 1'b1;
               cfg_use[`CPS_PAD_SCL] = 1'b1;
               cfg_oe[`CPS_PAD_SDA] = cfg_sda_oe_i;
            end
            `CPS_MODE_MSPI: begin
               cfg_use[`CPS_PAD_MCK] = 1'b1;
               cfg_use[`CPS_PAD_MCS] = 1'b1;
               cfg_use[`CPS_PAD_QIO0] = 1'b1;
               cfg_use[`CPS_PAD_QIO1] = 1'b1;
               cfg_out[`CPS_PAD_MCK] = cfg_sck_i;
               cfg_out[`CPS_PAD_MCS] = cfg_cs_n_i;
               cfg_out[`CPS_PAD_QIO0] = cfg_sout_i;
               cfg_oe[`CPS_PAD_MCK] = 1'b1;
               cfg_oe[`CPS_PAD_MCS] = 1'b1;
               cfg_oe[`CPS_PAD_QIO0] = 1'b1;
            end
            `CPS_MODE_MQSPI: begin
               cfg_use[`CPS_PAD_MCK] = 1'b1;
               cfg_use[`CPS_PAD_MCS] = 1'b1;
               cfg_use[`CPS_PAD_QIO3:`CPS_PAD_QIO0] = 4'hF;
               cfg_out[`CPS_PAD_MCK] = cfg_sck_i;
               cfg_out[`CPS_PAD_MCS] = cfg_cs_n_i;
               cfg_out[`CPS_PAD_QIO3:`CPS_PAD_QIO0] = cfg_qout_i;
               cfg_oe[`CPS_PAD_MCK] = 1'b1;
               cfg_oe[`CPS_PAD_MCS] = 1'b1;
               cfg_oe[`CPS_PAD_QIO3:`CPS_PAD_QIO0] = cfg_qoe_i;
            end
            `CPS_MODE_CHAIN: begin
               cfg_use[`CPS_PAD_MCK] = 1'b1;
               cfg_use[`CPS_PAD_MCS] = 1'b1;
               cfg_use[`CPS_PAD_QIO0] = 1'b1;
               cfg_use[`CPS_PAD_QIO1] = 1'b1;
               cfg_use[`CPS_PAD_CHN] = 1'b1;
               cfg_out[`CPS_PAD_MCK] = cfg_sck_i;
               cfg_out[`CPS_PAD_MCS] = cfg_cs_n_i;
               cfg_out[`CPS_PAD_QIO0] = cfg_sout_i;
               cfg_out[`CPS_PAD_CHN] = cfg_chain_cs_n_i;
               cfg_oe[`CPS_PAD_MCK] = 1'b1;
               cfg_oe[`CPS_PAD_MCS] = 1'b1;
               cfg_oe[`CPS_PAD_QIO0] = 1'b1;
               cfg_oe[`CPS_PAD_CHN] = 1'b1;
            end
            default: begin
               cfg_use = '0;
            end
         endcase
      end
   end

   // shared pad drive: configuration role, JTAG, user, or parked
   always_comb begin
      shared_pad_o = '0;
      shared_pad_oe_o = '0;
      shared_pad_pd_o = '0;
      if (cfg_phase) begin
         shared_pad_o = cfg_out;
         shared_pad_oe_o = cfg_oe;
         shared_pad_pd_o = ~cfg_use;
      end else begin
         shared_pad_o = user_pad_out_i;
         shared_pad_oe_o = user_pad_oe_i & user_pad_used_i;
         shared_pad_pd_o = ~user_pad_used_i;
         if (jtag_sel_i) begin
            shared_pad_o[`CPS_PAD_SOUT] = jtag_tdo_i;
            shared_pad_oe_o[`CPS_PAD_SOUT] = 1'b1;
            shared_pad_oe_o[`CPS_PAD_SCK:`CPS_PAD_SIN] = 3'h0;
            shared_pad_pd_o[`CPS_PAD_SCK:`CPS_PAD_SOUT] = 4'h0;
         end
      end
   end

   // inputs towards configuration engine, JTAG and user logic
   assign cfg_din_o = (mode_q == `CPS_MODE_MQSPI) ? shared_pad_i[`CPS_PAD_QIO3:`CPS_PAD_QIO0] :
      (mode_q == `CPS_MODE_SSPI) ? {3'h0, shared_pad_i[`CPS_PAD_SIN]} :
      (mode_q == `CPS_MODE_I2C) ? {3'h0, shared_pad_i[`CPS_PAD_SDA]} :
      {3'h0, shared_pad_i[`CPS_PAD_QIO1]};
   assign cfg_sck_o = shared_pad_i[`CPS_PAD_SCK];
   assign cfg_cs_n_o = shared_pad_i[`CPS_PAD_SCS];
   assign cfg_scl_o = shared_pad_i[`CPS_PAD_SCL];
   assign jtag_tdi_o = user_phase && jtag_sel_i && shared_pad_i[`CPS_PAD_SIN];
   assign jtag_tms_o = user_phase && jtag_sel_i && shared_pad_i[`CPS_PAD_SCS];
   assign jtag_tck_o = user_phase && jtag_sel_i && shared_pad_i[`CPS_PAD_SCK];
   assign user_pad_in_o = user_phase ? shared_pad_i : '0;

   // ordinary top-bank user pads
   assign top_user_pad_o = user_phase ? top_user_pad_out_i : '0;
   assign top_user_pad_oe_o = user_phase ? (top_user_pad_oe_i & top_user_pad_used_i) : '0;
   assign top_user_pad_pd_o = user_phase ? ~top_user_pad_used_i : '1;
   assign top_user_pad_in_o = user_phase ? top_user_pad_i : '0;

   // checks
   property p_restart;
      @(posedge clk_i) disable iff (sys_rst_i)
      !restart_s |=> state_q == cps_pkg::CPS_ST_INIT;
   endproperty
   a_restart: assert property (p_restart) else $error("restart ignored");

   property p_od;
      @(posedge clk_i) disable iff (sys_rst_i)
      !init_state_n_o && !done_n_o;
   endproperty
   a_od: assert property (p_od) else $error("status pin driven high");

   property p_init_low;
      @(posedge clk_i) disable iff (sys_rst_i)
      state_q == cps_pkg::CPS_ST_INIT |-> init_state_n_oe_o;
   endproperty
   a_init_low: assert property (p_init_low) else $error("init pin not low");

   property p_init_rel;
      @(posedge clk_i) disable iff (sys_rst_i)
      load_busy_o |-> !init_state_n_oe_o && $past(init_s);
   endproperty
   a_init_rel: assert property (p_init_rel) else $error("load before init release");

   property p_hold_init;
      @(posedge clk_i) disable iff (sys_rst_i)
      state_q == cps_pkg::CPS_ST_WAIT_INIT && !init_s && restart_s |=> !load_busy_o;
   endproperty
   a_hold_init: assert property (p_hold_init) else $error("load while init held");

   property p_done_low;
      @(posedge clk_i) disable iff (sys_rst_i)
      load_busy_o |-> done_n_oe_o;
   endproperty
   a_done_low: assert property (p_done_low) else $error("done released early");

   property p_done_rel;
      @(posedge clk_i) disable iff (sys_rst_i)
      load_busy_o && load_ok_i && restart_s |=> !done_n_oe_o;
   endproperty
   a_done_rel: assert property (p_done_rel) else $error("done not released");

   property p_wake;
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(user_mode_o) |-> $past(done_s);
   endproperty
   a_wake: assert property (p_wake) else $error("woke with done low");

   property p_park;
      @(posedge clk_i) disable iff (sys_rst_i)
      !user_mode_o |-> top_user_pad_oe_o == '0 && top_user_pad_pd_o == '1;
   endproperty
   a_park: assert property (p_park) else $error("user pad active in config");

   property p_jtag;
      @(posedge clk_i) disable iff (sys_rst_i)
      user_mode_o && jtag_sel_i |-> shared_pad_oe_o[`CPS_PAD_SOUT] && shared_pad_o[`CPS_PAD_SOUT] == jtag_tdo_i;
   endproperty
   a_jtag: assert property (p_jtag) else $error("jtag tdo not mapped");

   c_load: cover property (@(posedge clk_i) disable iff (sys_rst_i) load_busy_o);
   c_user: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(user_mode_o));
   c_quad: cover property (@(posedge clk_i) disable iff (sys_rst_i) load_busy_o && mode_q == `CPS_MODE_MQSPI);
   c_jtag: cover property (@(posedge clk_i) disable iff (sys_rst_i) user_mode_o && jtag_sel_i);
endmodule

// ==== rtl/cps_map.svh ====
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH

// number of user pads in the top bank that are modelled
`define CPS_NUM_USER 8
// internal initialization time in cycles
`define CPS_INIT_CYCLES 16'h0040
// width of the initialization counter
`define CPS_INIT_W 16
// configuration mode encodings
`define CPS_MODE_SSPI 3'h0
`define CPS_MODE_I2C 3'h1
`define CPS_MODE_MSPI 3'h2
`define CPS_MODE_MQSPI 3'h3
`define CPS_MODE_CHAIN 3'h4
// pad indices of the shared configuration pads
`define CPS_PAD_SOUT 0
`define CPS_PAD_SIN 1
`define CPS_PAD_SCS 2
`define CPS_PAD_SCK 3
`define CPS_PAD_SDA 4
`define CPS_PAD_SCL 5
`define CPS_PAD_MCK 6
`define CPS_PAD_MCS 7
`define CPS_PAD_QIO0 8
`define CPS_PAD_QIO1 9
`define CPS_PAD_QIO2 10
`define CPS_PAD_QIO3 11
`define CPS_PAD_CHN 12
`define CPS_NUM_SHARED 13

`endif

// ==== rtl/cps_pkg.sv ====
package cps_pkg;
   typedef enum logic [2:0] {
      CPS_ST_IDLE = 3'b000,
      CPS_ST_INIT = 3'b001,
      CPS_ST_WAIT_INIT = 3'b010,
      CPS_ST_LOAD = 3'b011,
      CPS_ST_WAIT_DONE = 3'b100,
      CPS_ST_USER = 3'b101
   } cps_state_type;
endpackage

// ==== rtl/cps_sync_if.sv ====
`timescale 1ns/100ps
interface cps_sync_if;
   logic [2:0] raw;
   logic [2:0] synced;
   modport owner (output raw, input synced);
   modport sync (input raw, output synced);
endinterface

// ==== rtl/cps_sync2.sv ====
`timescale 1ns/100ps
// two-flop synchroniser for each bit of the carrier
module cps_sync2 (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   cps_sync_if.sync sif
);
   logic [2:0] meta_q;
   logic [2:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
      end else begin
         meta_q <= sif.raw;
         sync_q <= meta_q;
      end
   end

   assign sif.synced = sync_q;
endmodule

// ==== sim/cps_host_model.sv ====
`timescale 1ns/100ps
// board-side host: owns the restart pin and may stretch both open-drain status lines
module cps_host_model (
   input wire logic restart_req_i,
   input wire logic hold_init_i,
   input wire logic hold_done_i,
   input wire logic dev_init_oe_i,
   input wire logic dev_done_oe_i,
   output logic config_restart_n_o,
   output logic init_pad_o,
   output logic done_pad_o
);
   // restart pin is pulled low only while a new sequence is wanted
   assign config_restart_n_o = ~restart_req_i;
   // status lines have pull-ups; either party may pull them low
   assign init_pad_o = ~(dev_init_oe_i | hold_init_i);
   assign done_pad_o = ~(dev_done_oe_i | hold_done_i);
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/100ps
`include "cps_map.svh"
module tb;
   logic clk_i, sys_rst_i, config_restart_n_i, init_state_n_i, done_n_i;
   logic init_state_n_o, init_state_n_oe_o, done_n_o, done_n_oe_o;
   logic slave_spi_active_i, slave_i2c_active_i, master_mode_i, quad_mode_i, chain_mode_i;
   logic load_ok_i, jtag_sel_i, load_busy_o, user_mode_o;
   logic [2:0] mode_o;
   logic [`CPS_NUM_SHARED-1:0] shared_pad_i, shared_pad_o, shared_pad_oe_o, shared_pad_pd_o, ext_pad;
   logic cfg_sout_i, cfg_sck_i, cfg_cs_n_i, cfg_sda_oe_i, cfg_chain_cs_n_i, cfg_sck_o, cfg_cs_n_o, cfg_scl_o;
   logic [3:0] cfg_qout_i, cfg_qoe_i, cfg_din_o;
   logic [`CPS_NUM_SHARED-1:0] user_pad_out_i, user_pad_oe_i, user_pad_used_i, user_pad_in_o;
   logic jtag_tdo_i, jtag_tdi_o, jtag_tms_o, jtag_tck_o;
   logic [`CPS_NUM_USER-1:0] top_user_pad_i, top_user_pad_out_i, top_user_pad_oe_i, top_user_pad_used_i;
   logic [`CPS_NUM_USER-1:0] top_user_pad_o, top_user_pad_oe_o, top_user_pad_pd_o, top_user_pad_in_o, top_ext;
   logic restart_req, hold_init, hold_done;
   logic [4:0] straps;
   int bad_count = 0;
   int n_checks = 0;

   // pad wires: the device drives where enabled, otherwise the board level shows
   assign shared_pad_i = (shared_pad_oe_o & shared_pad_o) | (~shared_pad_oe_o & ext_pad);
   assign top_user_pad_i = (top_user_pad_oe_o & top_user_pad_o) | (~top_user_pad_oe_o & top_ext);
   assign {slave_spi_active_i, slave_i2c_active_i, master_mode_i, quad_mode_i, chain_mode_i} = straps;

   cps_sequencer u_cps_sequencer (
      .clk_i, .sys_rst_i, .config_restart_n_i, .init_state_n_i, .init_state_n_o, .init_state_n_oe_o,
      .done_n_i, .done_n_o, .done_n_oe_o, .slave_spi_active_i, .slave_i2c_active_i, .master_mode_i,
      .quad_mode_i, .chain_mode_i, .load_ok_i, .jtag_sel_i, .load_busy_o, .user_mode_o, .mode_o,
      .shared_pad_i, .shared_pad_o, .shared_pad_oe_o, .shared_pad_pd_o, .cfg_sout_i, .cfg_sck_i,
      .cfg_cs_n_i, .cfg_qout_i, .cfg_qoe_i, .cfg_sda_oe_i, .cfg_chain_cs_n_i, .cfg_din_o, .cfg_sck_o,
      .cfg_cs_n_o, .cfg_scl_o, .user_pad_out_i, .user_pad_oe_i, .user_pad_used_i, .user_pad_in_o,
      .jtag_tdo_i, .jtag_tdi_o, .jtag_tms_o, .jtag_tck_o, .top_user_pad_i, .top_user_pad_out_i,
      .top_user_pad_oe_i, .top_user_pad_used_i, .top_user_pad_o, .top_user_pad_oe_o,
      .top_user_pad_pd_o, .top_user_pad_in_o
   );

   cps_host_model u_cps_host_model (
      .restart_req_i(restart_req), .hold_init_i(hold_init), .hold_done_i(hold_done),
      .dev_init_oe_i(init_state_n_oe_o), .dev_done_oe_i(done_n_oe_o),
      .config_restart_n_o(config_restart_n_i), .init_pad_o(init_state_n_i), .done_pad_o(done_n_i)
   );

   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // level of the design output that a bounded wait watches
   function automatic logic pick(input int sel);
      case (sel)
         0: return init_state_n_oe_o;
         1: return load_busy_o;
         2: return done_n_oe_o;
         default: return user_mode_o;
      endcase
   endfunction

   // bounded wait for a design output to reach a level
   task automatic wait_sig(input string name, input int sel, input logic val, input int lim);
      int i;
      i = 0;
      while (pick(sel) !== val && i < lim) begin
         step(1);
         i++;
      end
      check(name, 16'(val), 16'(pick(sel)));
   endtask

   task finish_test;
      if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // restart with given straps, host stretches init, then lets the download begin
   task automatic start_cfg(input logic [4:0] s);
      straps = s;
      hold_init = 1'b1;
      restart_req = 1'b1;
      step(4);
      check("init_oe", 16'h0001, 16'(init_state_n_oe_o));
      check("done_oe", 16'h0001, 16'(done_n_oe_o));
      check("od_levels", 16'h0000, 16'({init_state_n_o, done_n_o}));
      check("top_oe_cfg", 16'h0000, 16'(top_user_pad_oe_o));
      check("top_pd_cfg", 16'h00FF, 16'(top_user_pad_pd_o));
      restart_req = 1'b0;
      wait_sig("init_release", 0, 1'b0, 90);
      step(20);
      check("load_held", 16'h0000, 16'(load_busy_o));
      hold_init = 1'b0;
      wait_sig("load_start", 1, 1'b1, 5);
      check("done_oe_load", 16'h0001, 16'(done_n_oe_o));
   endtask

   // each mode: pad roles during download, engine values swung both ways
   task automatic t_modes;
      logic [4:0] st [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
      logic [2:0] md [5] = '{`CPS_MODE_SSPI, `CPS_MODE_I2C, `CPS_MODE_MSPI, `CPS_MODE_MQSPI, `CPS_MODE_CHAIN};
      for (int i = 0; i < 5; i++) begin
         start_cfg(st[i]);
         check("mode", 16'(md[i]), 16'(mode_o));
         for (int v = 0; v < 2; v++) begin
            {cfg_sck_i, cfg_cs_n_i, cfg_sout_i, cfg_chain_cs_n_i, cfg_sda_oe_i} = v[0] ? 5'h15 : 5'h0A;
            cfg_qoe_i = v[0] ? 4'hA : 4'h5;
            cfg_qout_i = v[0] ? 4'hC : 4'h3;
            ext_pad = v[0] ? 13'h0AAA : 13'h1555;
            step(1);
            case (i)
               0: begin
                  check("sspi_sck", 16'(ext_pad[3]), 16'(cfg_sck_o));
                  check("sspi_cs", 16'(ext_pad[2]), 16'(cfg_cs_n_o));
                  check("sspi_idle_oe", 16'h0000, 16'(shared_pad_oe_o[12:4]));
                  check("sspi_out", 16'(cfg_sout_i), 16'(shared_pad_o[0]));
                  check("sspi_in", 16'(ext_pad[1]), 16'(cfg_din_o));
                  check("sspi_pd", 16'h1FF0, 16'(shared_pad_pd_o));
               end
               1: begin
                  check("i2c_scl", 16'(ext_pad[5]), 16'(cfg_scl_o));
                  check("i2c_sda_oe", 16'(cfg_sda_oe_i), 16'(shared_pad_oe_o[4]));
                  check("i2c_idle_oe", 16'h0000, 16'(shared_pad_oe_o[3:0]));
               end
               2: begin
                  check("mspi_oe", 16'h0007, 16'({shared_pad_oe_o[9], shared_pad_oe_o[8:6]}));
                  check("mspi_out", 16'({cfg_sout_i, cfg_cs_n_i, cfg_sck_i}), 16'(shared_pad_o[8:6]));
                  check("mspi_idle_oe", 16'h0000, 16'(shared_pad_oe_o[3:0]));
                  check("mspi_in", 16'(ext_pad[9]), 16'(cfg_din_o));
               end
               3: begin
                  check("quad_oe", 16'(cfg_qoe_i), 16'(shared_pad_oe_o[11:8]));
                  check("quad_out", 16'(cfg_qout_i & cfg_qoe_i), 16'(shared_pad_o[11:8] & cfg_qoe_i));
                  check("quad_in", 16'(cfg_qoe_i & cfg_qout_i | ~cfg_qoe_i & ext_pad[11:8]), 16'(cfg_din_o));
               end
               default: begin
                  check("chain_cs", 16'({1'b1, cfg_chain_cs_n_i}), 16'({shared_pad_oe_o[12], shared_pad_o[12]}));
               end
            endcase
         end
      end
   endtask

   // completion, wake-up held by host, pad hand-over and port selection
   task automatic t_user;
      start_cfg(5'h10);
      hold_done = 1'b1;
      load_ok_i = 1'b1;
      step(1);
      load_ok_i = 1'b0;
      wait_sig("done_release", 2, 1'b0, 3);
      step(10);
      check("user_held", 16'h0000, 16'(user_mode_o));
      hold_done = 1'b0;
      wait_sig("user_entry", 3, 1'b1, 5);
      check("gpio_oe", 16'(user_pad_oe_i[4]), 16'(shared_pad_oe_o[4]));
      check("gpio_out", 16'(user_pad_out_i[4]), 16'(shared_pad_o[4]));
      check("gpio_in", 16'(shared_pad_i[5]), 16'(user_pad_in_o[5]));
      check("jtag_off", 16'h0000, 16'(jtag_tck_o));
      check("top_used_oe", 16'(top_user_pad_oe_i & top_user_pad_used_i), 16'(top_user_pad_oe_o));
      check("top_unused_pd", 16'h000F, 16'(top_user_pad_pd_o[7:4]));
      check("top_out", 16'(top_user_pad_out_i[3:0]), 16'(top_user_pad_o[3:0]));
      check("top_in", 16'h0035, 16'(top_user_pad_in_o));
      jtag_sel_i = 1'b1;
      step(1);
      check("jtag_in", 16'(ext_pad[3:1]), 16'({jtag_tck_o, jtag_tms_o, jtag_tdi_o}));
      check("jtag_tdo", 16'(jtag_tdo_i), 16'(shared_pad_o[0]));
      jtag_sel_i = 1'b0;
      step(1);
   endtask

   // restart from user mode goes through the synchronisers first
   task automatic t_restart;
      restart_req = 1'b1;
      step(1);
      check("sync_delay", 16'h0001, 16'(user_mode_o));
      step(3);
      check("restart_user", 16'h0000, 16'(user_mode_o));
      check("restart_init", 16'h0003, 16'({init_state_n_oe_o, done_n_oe_o}));
      restart_req = 1'b0;
      step(2);
   endtask

   // main sequence
   initial begin
      sys_rst_i = 1'b1;
      {restart_req, hold_init, hold_done, load_ok_i, jtag_sel_i, jtag_tdo_i} = 6'h01;
      straps = 5'h10;
      {cfg_sout_i, cfg_sck_i, cfg_cs_n_i, cfg_sda_oe_i, cfg_chain_cs_n_i} = 5'h06;
      cfg_qout_i = 4'h0;
      cfg_qoe_i = 4'h0;
      ext_pad = 13'h1555;
      user_pad_out_i = 13'h0A5A;
      user_pad_oe_i = 13'h1FF0;
      user_pad_used_i = 13'h1FFF;
      top_ext = 8'h3C;
      top_user_pad_out_i = 8'hA5;
      top_user_pad_oe_i = 8'hFF;
      top_user_pad_used_i = 8'h0F;
      repeat (10) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      t_modes();
      t_user();
      t_restart();
      finish_test();
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      finish_test();
   end
endmodule
